// [core/conv_ctrl.sv]
// register file and sequencer of a 10-bit successive-approximation converter, AXI4-Lite slave
// assumes the analog core answers each start with one done pulse carrying the result, not while idle
//
// Notes on behaviour
// - reference select change takes effect only after the running conversion completes
// - reference code: 00 external pin, 01 supply, 10 internal 1.1V, 11 internal 2.56V
// - left adjust bit reformats presented data immediately, even mid-conversion
// - channel code: 0-7 single-ended, 8 upward differential pairs, 1e bandgap, 1f ground
// - channel and gain change deferred until running conversion completes
// - enable bit powers converter; clearing it aborts a running conversion
// - writing one to start begins a single conversion or the first free-running one
// - first conversion after enabling takes 25 converter clocks, later ones 13
// - start reads one while converting, zero after; writing zero does nothing
// - with auto trigger enabled, a rising edge of the selected trigger starts one unless trigger select is written that cycle; edges mid-conversion queue only one
// - done flag sets when a conversion finishes, even when a result lock keeps the data registers from updating
// - done flag clears on interrupt vector acknowledge or by writing one to it
// - interrupt request needs irq enable, global enable and done flag all set
// - prescaler: 000 and 001 divide by 2, then 4 to 128 for 111
// - reading low byte locks result updates until high byte is read
// - differential results are presented as two's complement values
// - right adjusted: result bits 7..0 in low byte, read-only, reset zero
// - right adjusted: result bits 9..8 in high byte bits 1..0, rest zero
// - left adjusted: bits 9..2 in high byte, bits 1..0 in low byte bits 7..6
// - selecting free running trigger source creates no trigger event itself
`timescale 1ns/1ps
`default_nettype none
`include "conv_ctrl_consts.svh"
module conv_ctrl
  import conv_ctrl_pkg::*;
(
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  input  wire logic [`ADDR_BITS-1:0] s_axi_awaddr_i,
  input  wire logic                 s_axi_awvalid_i,
  output logic                      s_axi_awready_o,
  input  wire logic [31:0]          s_axi_wdata_i,
  input  wire logic [3:0]           s_axi_wstrb_i,
  input  wire logic                 s_axi_wvalid_i,
  output logic                      s_axi_wready_o,
  output logic [1:0]                s_axi_bresp_o,
  output logic                      s_axi_bvalid_o,
  input  wire logic                 s_axi_bready_i,
  input  wire logic [`ADDR_BITS-1:0] s_axi_araddr_i,
  input  wire logic                 s_axi_arvalid_i,
  output logic                      s_axi_arready_o,
  output logic [31:0]               s_axi_rdata_o,
  output logic [1:0]                s_axi_rresp_o,
  output logic                      s_axi_rvalid_o,
  input  wire logic                 s_axi_rready_i,
  input  wire logic [7:0]           trigger_sources_i,
  input  wire logic                 global_irq_enable_i,
  input  wire logic                 irq_ack_i,
  output logic                      irq_o,
  output logic                      converter_power_o,
  output logic                      conv_clock_en_o,
  output logic                      conv_start_o,
  output analog_sel_s               analog_sel_o,
  input  wire logic                 conv_done_i,
  input  wire logic [9:0]           conv_result_i
);
  // software visible state
  logic [7:0]  input_reference_select;
  logic        converter_enable;
  logic        auto_trigger_enable;
  logic        conversion_done_flag;
  logic        conversion_irq_enable;
  logic [2:0]  clock_prescale_select;
  logic [2:0]  trigger_source_select;
  logic [9:0]  result;
  logic        result_locked;
  // sequencer state
  seq_state_e  state;
  logic        first_pending;
  logic [4:0]  cycle_count;
  logic [4:0]  cycle_target;
  logic [6:0]  prescale_count;
  logic        trigger_prev;
  logic        start_pending;
  input_kind_e sel_kind;
  gain_e       sel_gain;

  // ---------------- AXI4-Lite write path ----------------
  logic                  aw_held;
  logic                  w_held;
  logic [`ADDR_BITS-1:0] aw_addr;
  logic [7:0]            w_byte;
  logic                  w_lane0;
  wire                   wr_fire    = aw_held && w_held && !s_axi_bvalid_o;
  wire                   wr_ok      = wr_fire && w_lane0;
  // word index of the access; the two byte bits are ignored, registers are word aligned
  wire [`ADDR_BITS-1:0]  wr_word    = {2'b00, aw_addr[`ADDR_BITS-1:2]};
  wire                   wr_mux     = wr_ok && wr_word == `OFS_INPUT_REF_SEL;
  wire                   wr_csa     = wr_ok && wr_word == `OFS_CTRL_STATUS_A;
  wire                   wr_csb     = wr_ok && wr_word == `OFS_CTRL_STATUS_B;
  wire                   wr_mapped  = wr_word == `OFS_INPUT_REF_SEL || wr_word == `OFS_CTRL_STATUS_A ||
                                      wr_word == `OFS_CTRL_STATUS_B || wr_word == `OFS_RESULT_LOW ||
                                      wr_word == `OFS_RESULT_HIGH;

  assign s_axi_awready_o = !aw_held;
  assign s_axi_wready_o  = !w_held;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held        <= 1'b0;
      w_held         <= 1'b0;
      aw_addr        <= '0;
      w_byte         <= `RST_BYTE;
      w_lane0        <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= 2'b00;
    end else begin
      if (s_axi_awvalid_i && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && !w_held) begin
        w_held  <= 1'b1;
        // every register here is one byte, so only lane 0 of an aligned word matters
        w_byte  <= s_axi_wdata_i[7:0];
        w_lane0 <= s_axi_wstrb_i[0];
      end
      if (wr_fire) begin
        aw_held        <= 1'b0;
        w_held         <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_mapped ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // ---------------- AXI4-Lite read path ----------------
  wire [`ADDR_BITS-1:0] rd_word = {2'b00, s_axi_araddr_i[`ADDR_BITS-1:2]};
  wire                  rd_fire = s_axi_arvalid_i && !s_axi_rvalid_o;
  wire                  rd_low  = rd_fire && rd_word == `OFS_RESULT_LOW;
  wire                  rd_high = rd_fire && rd_word == `OFS_RESULT_HIGH;
  wire                  left    = input_reference_select[`BIT_LEFT_ADJUST];
  // formatting is combinational on the live bit, so a change shows at once
  wire [7:0] low_byte  = left ? {result[1:0], 6'b000000} : result[7:0];
  wire [7:0] high_byte = left ? result[9:2] : {6'b000000, result[9:8]};
  wire [7:0] csa_byte  = {converter_enable, state == SEQ_RUN || start_pending,
                          auto_trigger_enable, conversion_done_flag, conversion_irq_enable,
                          clock_prescale_select};
  wire [7:0] csb_byte  = {5'b00000, trigger_source_select};
  logic [7:0] rd_byte;
  logic       rd_mapped;
  always_comb begin
    rd_byte   = 8'h00;
    rd_mapped = 1'b1;
    case (rd_word)
      `OFS_RESULT_LOW:    rd_byte = low_byte;
      `OFS_RESULT_HIGH:   rd_byte = high_byte;
      `OFS_CTRL_STATUS_A: rd_byte = csa_byte;
      `OFS_CTRL_STATUS_B: rd_byte = csb_byte;
      `OFS_INPUT_REF_SEL: rd_byte = input_reference_select;
      default:            rd_mapped = 1'b0;
    endcase
  end
  assign s_axi_arready_o = !s_axi_rvalid_o;
  wire s_axi_rvalid_i_done = s_axi_rvalid_o && s_axi_rready_i;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= 2'b00;
    end else if (rd_fire) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= {24'h000000, rd_byte};
      s_axi_rresp_o  <= rd_mapped ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid_i_done) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ---------------- trigger and start ----------------
  wire trigger_now   = trigger_sources_i[trigger_source_select];
  wire conv_done_ok  = state == SEQ_RUN && conv_done_i && cycle_count >= cycle_target;
  // free running retriggers on every completion pulse, so a flag left set never stalls it,
  // and switching to free running sees no level and thus makes no edge
  wire trigger_level = (trigger_source_select == `TRIG_FREE_RUN) ? conv_done_ok : trigger_now;
  wire trigger_edge  = auto_trigger_enable && trigger_level && !trigger_prev && !wr_csb;
  wire start_write   = wr_csa && w_byte[`BIT_START];
  wire next_enable   = wr_csa ? w_byte[`BIT_ENABLE] : converter_enable;

  // ---------------- prescaler ----------------
  logic [6:0] prescale_top;
  always_comb begin
    case (clock_prescale_select)
      3'd2:    prescale_top = 7'd3;
      3'd3:    prescale_top = 7'd7;
      3'd4:    prescale_top = 7'd15;
      3'd5:    prescale_top = 7'd31;
      3'd6:    prescale_top = 7'd63;
      3'd7:    prescale_top = 7'd127;
      default: prescale_top = 7'd1;
    endcase
  end
  wire tick = converter_enable && state == SEQ_RUN && prescale_count == prescale_top;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prescale_count <= 7'd0;
    end else if (!converter_enable || state != SEQ_RUN || tick) begin
      prescale_count <= 7'd0;
    end else begin
      prescale_count <= prescale_count + 7'd1;
    end
  end
  assign conv_clock_en_o   = tick;
  assign converter_power_o = converter_enable;

  // ---------------- registers and sequencer ----------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      input_reference_select <= `RST_BYTE;
      converter_enable       <= 1'b0;
      auto_trigger_enable    <= 1'b0;
      conversion_done_flag   <= 1'b0;
      conversion_irq_enable  <= 1'b0;
      clock_prescale_select  <= 3'd0;
      trigger_source_select  <= 3'd0;
      result                 <= 10'd0;
      result_locked          <= 1'b0;
      state                  <= SEQ_IDLE;
      first_pending          <= 1'b1;
      cycle_count            <= 5'd0;
      cycle_target           <= `NORMAL_CONV_CYCLES;
      trigger_prev           <= 1'b0;
      start_pending          <= 1'b0;
      conv_start_o           <= 1'b0;
      analog_sel_o           <= '0;
    end else begin
      conv_start_o <= 1'b0;
      trigger_prev <= trigger_level;
      if (wr_mux) begin
        input_reference_select <= w_byte;
      end
      if (wr_csa) begin
        converter_enable      <= w_byte[`BIT_ENABLE];
        auto_trigger_enable   <= w_byte[`BIT_AUTO_TRIG];
        conversion_irq_enable <= w_byte[`BIT_IRQ_ENABLE];
        clock_prescale_select <= w_byte[2:0];
      end
      if (wr_csb) begin
        trigger_source_select <= w_byte[2:0];
      end
      if (rd_low) begin
        result_locked <= 1'b1;
      end else if (rd_high) begin
        result_locked <= 1'b0;
      end
      // clear first, set last: a completion in the clearing cycle wins
      if ((wr_csa && w_byte[`BIT_DONE_FLAG]) || irq_ack_i) begin
        conversion_done_flag <= 1'b0;
      end
      if (!next_enable) begin
        state         <= SEQ_IDLE;
        start_pending <= 1'b0;
        first_pending <= 1'b1;
        cycle_count   <= 5'd0;
      end else begin
        case (state)
          SEQ_IDLE: begin
            if (start_write || trigger_edge || start_pending) begin
              state         <= SEQ_RUN;
              start_pending <= 1'b0;
              conv_start_o  <= 1'b1;
              cycle_count   <= 5'd0;
              cycle_target  <= first_pending ? `INIT_CONV_CYCLES : `NORMAL_CONV_CYCLES;
              first_pending <= 1'b0;
              // selections are sampled only at a start, so mid-conversion writes wait
              analog_sel_o.ref_mode            <= ref_mode_e'(input_reference_select[7:6]);
              analog_sel_o.channel_gain_select <= input_reference_select[4:0];
              analog_sel_o.kind                <= sel_kind;
              analog_sel_o.gain                <= sel_gain;
            end
          end
          SEQ_RUN: begin
            if (tick && cycle_count < cycle_target) begin
              cycle_count <= cycle_count + 5'd1;
            end
            if (start_write || trigger_edge) begin
              start_pending <= auto_trigger_enable && trigger_edge;
            end
            if (conv_done_ok) begin
              state <= SEQ_IDLE;
              if (!result_locked) begin
                // differential codes arrive already in two's complement and are kept as is
                result <= conv_result_i;
              end
              conversion_done_flag <= 1'b1;
            end
          end
          default: state <= SEQ_IDLE;
        endcase
      end
    end
  end

  // channel code decode toward the analog core
  wire [4:0] ch = input_reference_select[4:0];
  always_comb begin
    sel_gain = GAIN_1X;
    if (ch == `CHAN_BANDGAP) begin
      sel_kind = IN_BANDGAP;
    end else if (ch == `CHAN_GROUND) begin
      sel_kind = IN_GROUND;
    end else if (ch < `CHAN_DIFF_FIRST) begin
      sel_kind = IN_SINGLE;
    end else begin
      sel_kind = IN_DIFF;
      if (ch[4:3] == 2'b01) begin
        sel_gain = ch[1] ? GAIN_200X : GAIN_10X;
      end
    end
  end

  assign irq_o = conversion_irq_enable && global_irq_enable_i && conversion_done_flag;
endmodule
`default_nettype wire

// [core/conv_ctrl_consts.svh]
// register indices, field positions, reset values and timing counts of the converter control block
// each register owns one aligned bus word: its byte address is four times its index
// included by the package and by the control module
`ifndef CONV_CTRL_CONSTS_SVH
`define CONV_CTRL_CONSTS_SVH
`define OFS_RESULT_LOW       12'h078
`define OFS_RESULT_HIGH      12'h079
`define OFS_CTRL_STATUS_A    12'h07a
`define OFS_CTRL_STATUS_B    12'h07b
`define OFS_INPUT_REF_SEL    12'h07c
`define RST_BYTE             8'h00
`define BIT_ENABLE           7
`define BIT_START            6
`define BIT_AUTO_TRIG        5
`define BIT_DONE_FLAG        4
`define BIT_IRQ_ENABLE       3
`define BIT_LEFT_ADJUST      5
`define INIT_CONV_CYCLES     5'd25
`define NORMAL_CONV_CYCLES   5'd13
`define CHAN_DIFF_FIRST      5'h08
`define CHAN_BANDGAP         5'h1e
`define CHAN_GROUND          5'h1f
`define TRIG_FREE_RUN        3'h0
`define ADDR_BITS            12
`endif

// [core/conv_ctrl_pkg.sv]
// types of the converter control block
// no assumptions beyond the constants header
`include "conv_ctrl_consts.svh"
package conv_ctrl_pkg;
  typedef enum logic [1:0] {
    REF_EXT_PIN,
    REF_SUPPLY,
    REF_INT_1V1,
    REF_INT_2V56
  } ref_mode_e;
  typedef enum logic [1:0] {
    IN_SINGLE,
    IN_DIFF,
    IN_BANDGAP,
    IN_GROUND
  } input_kind_e;
  typedef enum logic [1:0] {
    GAIN_1X,
    GAIN_10X,
    GAIN_200X
  } gain_e;
  // selection latched toward the analog core
  typedef struct packed {
    ref_mode_e   ref_mode;
    input_kind_e kind;
    gain_e       gain;
    logic [4:0]  channel_gain_select;
  } analog_sel_s;
  typedef enum {
    SEQ_IDLE,
    SEQ_RUN
  } seq_state_e;
endpackage

// [testbench/conv_core_model.sv]
// analog core model: counts converter clocks after a start, then one done pulse with the result
// expects one start per conversion; loss of power drops a conversion in flight
`timescale 1ns/1ps
`default_nettype none
module conv_core_model (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       power_i,
  input  wire logic       tick_i,
  input  wire logic       start_i,
  input  wire logic [4:0] lag_i,
  input  wire logic [9:0] value_i,
  output logic            done_o,
  output logic [9:0]      result_o
);
  logic       busy;
  logic       first;
  logic       pend;
  logic [4:0] cnt;
  int         ticks;
  // outside the done pulse the bus shows the inverse, so a stray sample is caught
  assign result_o = done_o ? value_i : ~value_i;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {busy, pend, done_o, cnt} <= '0;
      first <= 1'b1;
      ticks <= 0;
    end else begin
      done_o <= 1'b0;
      if (!power_i) begin
        {busy, pend} <= 2'b00;
        first <= 1'b1;
      end else if (start_i) begin
        busy  <= 1'b1;
        ticks <= 0;
      end else if (pend) begin
        cnt <= cnt - 5'h01;
        pend <= (cnt != 5'h01);
        done_o <= (cnt == 5'h01);
      end else if (busy && tick_i) begin
        ticks <= ticks + 1;
        if (ticks + 1 == (first ? 25 : 13)) begin
          {busy, first} <= 2'b00;
          done_o <= (lag_i == 5'h00);
          pend <= (lag_i != 5'h00);
          cnt <= lag_i;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/conv_ctrl_props.sv]
// assertions on the ports of the converter control block
// bound into conv_ctrl; one clock, asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl_props
  import conv_ctrl_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic        global_irq_enable_i,
  input wire logic        irq_o,
  input wire logic        converter_power_o,
  input wire logic        conv_clock_en_o,
  input wire logic        conv_start_o,
  input wire analog_sel_s analog_sel_o
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  a_irq_gated: assert property (irq_o |-> global_irq_enable_i)
    else $error("irq raised without global enable");
  a_no_tick_off: assert property (!converter_power_o |-> !conv_clock_en_o)
    else $error("converter clock while disabled");
  a_start_powered: assert property (conv_start_o |-> converter_power_o)
    else $error("start while disabled");
  // selection may move only around a start, never mid-conversion
  a_sel_latched: assert property (!$stable(analog_sel_o) |-> ##[0:1] conv_start_o)
    else $error("selection changed outside a start");
  a_tick_spacing: assert property (conv_clock_en_o |=> !conv_clock_en_o)
    else $error("converter clock above half rate");
  a_start_single: assert property (conv_start_o |=> !conv_start_o [*2])
    else $error("start pulses too close");
  a_write_done: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write response repeated");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  a_read_done: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("read answer repeated");
endmodule
bind conv_ctrl conv_ctrl_props conv_ctrl_props_inst (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .global_irq_enable_i(global_irq_enable_i), .irq_o(irq_o),
  .converter_power_o(converter_power_o), .conv_clock_en_o(conv_clock_en_o), .conv_start_o(conv_start_o),
  .analog_sel_o(analog_sel_o)
);
`default_nettype wire

// [testbench/tb.sv]
// self-checking bench: AXI4-Lite register access plus the analog core model
// one 100 MHz clock; the core model answers each start after the counted converter clocks
`timescale 1ns/1ps
`default_nettype none
module tb
  import conv_ctrl_pkg::*;
;
  logic        clock_i = 0, rst_n_i = 0, gie = 0, ack = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, irq, pwr, clk_en, start, done;
  logic [1:0]  bresp, rresp, r;
  logic [7:0]  trig = 0, q;
  logic [9:0]  value = 0, result;
  logic [4:0]  lag = 0;
  analog_sel_s sel;
  int          fails = 0, tests_run = 0, ticks = 0, starts = 0, gap = 0, last = 0, cyc = 0, n0;
  conv_ctrl conv_ctrl_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'h1),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .trigger_sources_i(trig), .global_irq_enable_i(gie), .irq_ack_i(ack), .irq_o(irq),
    .converter_power_o(pwr), .conv_clock_en_o(clk_en), .conv_start_o(start), .analog_sel_o(sel),
    .conv_done_i(done), .conv_result_i(result));
  conv_core_model conv_core_model_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .power_i(pwr),
    .tick_i(clk_en), .start_i(start), .lag_i(lag), .value_i(value), .done_o(done), .result_o(result));
  always #5 clock_i = ~clock_i;
  // tick count and spacing are measured here, not taken from the model
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (start) begin
      ticks <= 0;
      starts <= starts + 1;
    end else if (clk_en) begin
      ticks <= ticks + 1;
      gap <= cyc - last;
      last <= cyc;
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("FAIL t=%0t got %h expected %h", $time, s, e);
    end
  endtask
  // ready is sampled 1 ns after an edge, when this edge's updates have landed
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic ra, rw, rb;
    @(posedge clock_i);
    awaddr <= a; awvalid <= 1'b1; wdata <= {24'h0, d}; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      #1 ra = awvalid && awready; rw = wvalid && wready; rb = bvalid; r = bresp;
      @(posedge clock_i);
      if (ra) awvalid <= 1'b0;
      if (rw) wvalid <= 1'b0;
    end while (!rb);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    logic ra, rr;
    @(posedge clock_i);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      #1 ra = arvalid && arready; rr = rvalid; q = rdata[7:0]; r = rresp;
      @(posedge clock_i);
      if (ra) arvalid <= 1'b0;
    end while (!rr);
    rready <= 1'b0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    rd(a);
    chk(q, e);
  endtask
  task automatic wait_done();
    q = 0;
    for (int n = 0; n < 1000 && q[4] !== 1'b1; n++) rd(12'h1e8);
    chk(q[4], 1'b1);
  endtask
  task automatic report_and_stop();
    if (fails == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #300_000;
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rc(12'h1e0, 8'h00);
    rc(12'h1e4, 8'h00);
    rc(12'h1e8, 8'h00);
    rc(12'h1f0, 8'h00);
    rd(12'h100);
    chk(r, 2'h2);
    wr(12'h100, 8'hff);
    chk(r, 2'h2);
    value = 10'h270;
    wr(12'h1f0, 8'hed);
    wr(12'h1e8, 8'hc8);
    rc(12'h1e8, 8'hc8);
    chk(sel, analog_sel_s'{REF_INT_2V56, IN_DIFF, GAIN_10X, 5'h0d});
    wr(12'h1f0, 8'h3e);
    chk(sel, analog_sel_s'{REF_INT_2V56, IN_DIFF, GAIN_10X, 5'h0d});
    wait_done();
    chk(ticks, 25);
    chk(irq, 1'b0);
    gie <= 1'b1;
    rc(12'h1e8, 8'h98);
    chk(irq, 1'b1);
    rc(12'h1e0, 8'h00);
    rc(12'h1e4, 8'h9c);
    wr(12'h1f0, 8'h1e);
    rc(12'h1e0, 8'h70);
    rc(12'h1e4, 8'h02);
    @(posedge clock_i) ack <= 1'b1;
    @(posedge clock_i) ack <= 1'b0;
    rc(12'h1e8, 8'h88);
    chk(irq, 1'b0);
    value = 10'h155;
    wr(12'h1e8, 8'hc8);
    chk(sel.ref_mode, REF_EXT_PIN);
    chk(sel.kind, IN_BANDGAP);
    wait_done();
    chk(ticks, 13);
    wr(12'h1e8, 8'h98);
    rc(12'h1e8, 8'h88);
    rc(12'h1e0, 8'h55);
    value = 10'h2aa;
    lag <= 5'h03;
    wr(12'h1e8, 8'hc8);
    wait_done();
    rc(12'h1e4, 8'h01);
    wr(12'h1e8, 8'hd8);
    wait_done();
    rc(12'h1e0, 8'haa);
    rc(12'h1e4, 8'h02);
    lag <= 5'h00;
    wr(12'h1e8, 8'hd0);
    wr(12'h1e8, 8'h00);
    rc(12'h1e8, 8'h00);
    chk(pwr, 1'b0);
    repeat (60) @(posedge clock_i);
    rc(12'h1e8, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(12'h1e8, 8'hd0 | i[7:0]);
      if (i == 3) wr(12'h1e8, 8'h83);
      wait_done();
      chk(gap, (i < 2) ? 2 : (1 << i));
      chk(ticks, (i == 0) ? 25 : 13);
    end
    wr(12'h1ec, 8'h02);
    wr(12'h1e8, 8'hb0);
    n0 = starts;
    @(posedge clock_i) trig <= 8'h04;
    repeat (4) @(posedge clock_i);
    chk(starts, n0 + 1);
    wait_done();
    trig <= 8'h00;
    wr(12'h1ec, 8'h00);
    repeat (6) @(posedge clock_i);
    chk(starts, n0 + 1);
    wr(12'h1e8, 8'hf0);
    repeat (150) @(posedge clock_i);
    chk(starts > n0 + 3, 1'b1);
    wr(12'h1e8, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
